// File: src/dtp_pkg.sv
package dtp_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned NV_WRITE_US = 5000;
	localparam int unsigned NV_WRITE_MAX_US = 10000;
	localparam int unsigned NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
	localparam int unsigned NV_WRITE_MAX_CYC = NV_WRITE_MAX_US * CLK_MHZ;
	localparam int NV_CNT_W = 22;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int WIPER_W = 6;
	localparam int TAPS = 64;
	localparam int PRESETS = 4;
	localparam int SYNC_W = 6;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [5:0] WIPER_MAX = 6'h3F;
	localparam logic [5:0] WIPER_MIN = 6'h00;
	localparam logic [5:0] PRESET_RESET = 6'h00;
	localparam logic [5:0] LINE_IDLE = 6'h31;
	// Arbitrary identity value, not a real part code
	localparam logic [3:0] DEV_TYPE_DEFAULT = 4'hA;
	localparam logic ADDR_BIT1_DEFAULT = 1'h0;

	// ----------------------------------------
	// Instruction byte layout and opcodes
	// ----------------------------------------
	localparam int OP_MSB = 7;
	localparam int OP_LSB = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 2;
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'hA;
	localparam logic [3:0] OP_RD_PRESET = 4'hB;
	localparam logic [3:0] OP_WR_PRESET = 4'hC;
	localparam logic [3:0] OP_XFR_P2W = 4'hD;
	localparam logic [3:0] OP_XFR_W2P = 4'hE;
	localparam logic [3:0] OP_INCDEC = 4'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_CMD = 4'h3,
		ST_CMD_ACK = 4'h4,
		ST_DATA = 4'h5,
		ST_DATA_ACK = 4'h6,
		ST_TX = 4'h7,
		ST_TX_ACK = 4'h8,
		ST_INCDEC = 4'h9,
		ST_IGNORE = 4'hA
	} dtp_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic [2:0] strap;
		logic wp_n;
	} dtp_line_t;

	typedef struct packed {
		logic [1:0] sel;
		logic [5:0] data;
	} dtp_nv_req_t;

endpackage

// File: src/dtp_line_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dtp_line_sync
	import dtp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [2:0] addr_strap_inputs_i,
	input wire logic wp_n_i,
	output dtp_line_t line_o
);

	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] meta_nxt;
	logic [SYNC_W-1:0] sync_r;
	logic [SYNC_W-1:0] sync_nxt;
	logic [1:0] prev_r;
	logic [1:0] prev_nxt;

	// ----------------------------------------
	// Two-stage synchroniser, then history
	// ----------------------------------------
	always_comb begin
		meta_nxt = {scl_i, sda_i, addr_strap_inputs_i, wp_n_i};
		sync_nxt = meta_r;
		prev_nxt = sync_r[5:4];
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			meta_r <= LINE_IDLE;
			sync_r <= LINE_IDLE;
			prev_r <= 2'h3;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
		end
	end

	// Start/stop need the clock high on both samples
	always_comb begin
		line_o.scl = sync_r[5];
		line_o.sda = sync_r[4];
		line_o.strap = sync_r[3:1];
		line_o.wp_n = sync_r[0];
		line_o.scl_rise = sync_r[5] & ~prev_r[1];
		line_o.scl_fall = ~sync_r[5] & prev_r[1];
		line_o.start = sync_r[5] & prev_r[1] & prev_r[0] & ~sync_r[4];
		line_o.stop = sync_r[5] & prev_r[1] & ~prev_r[0] & sync_r[4];
	end

endmodule
`default_nettype wire

// File: src/dtp_tap_decode.sv
`timescale 1ns/100ps
`default_nettype none
module dtp_tap_decode
	import dtp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [WIPER_W-1:0] wiper_i,
	output logic [TAPS-1:0] tap_sel_o
);

	logic [TAPS-1:0] tap_nxt;

	function automatic logic [TAPS-1:0] onehot(input logic [WIPER_W-1:0] pos);
		logic [TAPS-1:0] v;
		v = '0;
		v[pos] = 1'b1;
		return v;
	endfunction

	always_comb begin
		tap_nxt = onehot(wiper_i);
	end

	// Reset value still selects exactly one switch
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tap_sel_o <= onehot(WIPER_MIN);
		end else begin
			tap_sel_o <= tap_nxt;
		end
	end

endmodule
`default_nettype wire

// File: src/dtp_slave.sv
`timescale 1ns/100ps
`default_nettype none
module dtp_slave
	import dtp_pkg::*;
#(
	parameter int unsigned NV_WRITE_CYCLES = NV_WRITE_CYC,
	parameter logic [3:0] DEV_TYPE_ID = DEV_TYPE_DEFAULT,
	parameter logic ADDR_BIT1 = ADDR_BIT1_DEFAULT
)
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic [2:0] addr_strap_inputs_i,
	input wire logic wp_n_i,
	output logic [WIPER_W-1:0] wiper_o,
	output logic [TAPS-1:0] tap_sel_o,
	output logic nv_busy_o
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	dtp_line_t line;
	dtp_state_t state_r;
	dtp_state_t state_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic drive_r;
	logic drive_nxt;
	logic [3:0] op_r;
	logic [3:0] op_nxt;
	logic [1:0] sel_r;
	logic [1:0] sel_nxt;

	logic ev_wiper_wr;
	logic ev_xfr;
	logic ev_nv;
	logic ev_step;
	logic ev_up;
	logic [WIPER_W-1:0] ev_data;
	logic addr_hit;

	logic [WIPER_W-1:0] wiper_r;
	logic [WIPER_W-1:0] wiper_nxt;
	logic [WIPER_W-1:0] preset_r [PRESETS];
	logic [WIPER_W-1:0] preset_nxt [PRESETS];
	logic pend_r;
	logic pend_nxt;
	dtp_nv_req_t req_r;
	dtp_nv_req_t req_nxt;
	logic busy_r;
	logic busy_nxt;
	logic [NV_CNT_W-1:0] timer_r;
	logic [NV_CNT_W-1:0] timer_nxt;
	logic recall_r;
	logic recall_nxt;

	function automatic logic op_known(input logic [3:0] op);
		case (op)
			OP_RD_WIPER, OP_WR_WIPER, OP_RD_PRESET, OP_WR_PRESET,
			OP_XFR_P2W, OP_XFR_W2P, OP_INCDEC: op_known = 1'b1;
			default: op_known = 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// Pin synchronisers and tap decoder
	// ----------------------------------------
	dtp_line_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.addr_strap_inputs_i(addr_strap_inputs_i),
		.wp_n_i(wp_n_i),
		.line_o(line)
	);

	dtp_tap_decode u_decode (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.wiper_i(wiper_r),
		.tap_sel_o(tap_sel_o)
	);

	// ----------------------------------------
	// Address compare
	// ----------------------------------------
	// Busy write makes polls go unanswered
	always_comb begin
		addr_hit = (shift_r[7:4] == DEV_TYPE_ID)
			&& (shift_r[3:0] == {line.strap[2], line.strap[1], ADDR_BIT1, line.strap[0]})
			&& !busy_r;
	end

	// ----------------------------------------
	// Serial protocol engine
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		drive_nxt = drive_r;
		op_nxt = op_r;
		sel_nxt = sel_r;
		ev_wiper_wr = 1'b0;
		ev_xfr = 1'b0;
		ev_nv = 1'b0;
		ev_step = 1'b0;
		ev_up = 1'b0;
		ev_data = wiper_r;
		if (line.stop) begin
			state_nxt = ST_IDLE;
			drive_nxt = 1'b0;
		end else if (line.start) begin
			state_nxt = ST_ADDR;
			cnt_nxt = 4'h0;
			drive_nxt = 1'b0;
		end else begin
			case (state_r)
				ST_ADDR, ST_CMD, ST_DATA: begin
					if (line.scl_rise && cnt_r != BYTE_BITS) begin
						shift_nxt = {shift_r[6:0], line.sda};
						cnt_nxt = cnt_r + 4'h1;
					end else if (line.scl_fall && cnt_r == BYTE_BITS) begin
						cnt_nxt = 4'h0;
						if (state_r == ST_ADDR) begin
							if (addr_hit) begin
								drive_nxt = 1'b1;
								state_nxt = ST_ADDR_ACK;
							end else begin
								state_nxt = ST_IGNORE;
							end
						end else if (state_r == ST_CMD) begin
							if (op_known(shift_r[OP_MSB:OP_LSB])) begin
								drive_nxt = 1'b1;
								op_nxt = shift_r[OP_MSB:OP_LSB];
								sel_nxt = shift_r[SEL_MSB:SEL_LSB];
								state_nxt = ST_CMD_ACK;
							end else begin
								state_nxt = ST_IGNORE;
							end
						end else begin
							drive_nxt = 1'b1;
							state_nxt = ST_DATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (line.scl_fall) begin
						drive_nxt = 1'b0;
						state_nxt = ST_CMD;
					end
				end
				ST_CMD_ACK: begin
					if (line.scl_fall) begin
						drive_nxt = 1'b0;
						state_nxt = ST_IGNORE;
						case (op_r)
							OP_RD_WIPER, OP_RD_PRESET: begin
								tx_nxt = {2'h0, (op_r == OP_RD_WIPER) ? wiper_r : preset_r[sel_r]};
								drive_nxt = ~tx_nxt[7];
								cnt_nxt = 4'h1;
								state_nxt = ST_TX;
							end
							OP_WR_WIPER, OP_WR_PRESET: begin
								state_nxt = ST_DATA;
							end
							OP_XFR_P2W: begin
								ev_xfr = 1'b1;
							end
							OP_XFR_W2P: begin
								ev_nv = 1'b1;
								ev_data = wiper_r;
							end
							OP_INCDEC: begin
								state_nxt = ST_INCDEC;
							end
							default: begin
								state_nxt = ST_IGNORE;
							end
						endcase
					end
				end
				ST_DATA_ACK: begin
					if (line.scl_fall) begin
						drive_nxt = 1'b0;
						state_nxt = ST_IGNORE;
						ev_data = shift_r[WIPER_W-1:0];
						if (op_r == OP_WR_WIPER) begin
							ev_wiper_wr = 1'b1;
						end else begin
							ev_nv = 1'b1;
						end
					end
				end
				ST_TX: begin
					if (line.scl_fall) begin
						if (cnt_r == BYTE_BITS) begin
							drive_nxt = 1'b0;
							state_nxt = ST_TX_ACK;
						end else begin
							tx_nxt = {tx_r[6:0], 1'b0};
							drive_nxt = ~tx_nxt[7];
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					// One byte per read; more clocks are ignored
					if (line.scl_fall) begin
						state_nxt = ST_IGNORE;
					end
				end
				ST_INCDEC: begin
					if (line.scl_rise) begin
						ev_step = 1'b1;
						ev_up = line.sda;
					end
				end
				default: begin
					drive_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			drive_r <= 1'b0;
			op_r <= 4'h0;
			sel_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			drive_r <= drive_nxt;
			op_r <= op_nxt;
			sel_r <= sel_nxt;
		end
	end

	// ----------------------------------------
	// Wiper, presets and nonvolatile write
	// ----------------------------------------
	always_comb begin
		wiper_nxt = wiper_r;
		preset_nxt = preset_r;
		pend_nxt = pend_r;
		req_nxt = req_r;
		busy_nxt = busy_r;
		timer_nxt = timer_r;
		recall_nxt = 1'b0;
		if (recall_r) begin
			wiper_nxt = preset_r[0];
		end
		if (ev_wiper_wr) begin
			wiper_nxt = ev_data;
		end
		if (ev_xfr) begin
			wiper_nxt = preset_r[sel_r];
		end
		if (ev_step) begin
			if (ev_up && wiper_r != WIPER_MAX) begin
				wiper_nxt = wiper_r + 6'h01;
			end else if (!ev_up && wiper_r != WIPER_MIN) begin
				wiper_nxt = wiper_r - 6'h01;
			end
		end
		// Commit waits for stop so an aborted frame writes nothing
		if (ev_nv) begin
			pend_nxt = 1'b1;
			req_nxt.sel = sel_r;
			req_nxt.data = ev_data;
		end else if (line.start) begin
			pend_nxt = 1'b0;
		end else if (line.stop) begin
			pend_nxt = 1'b0;
			if (pend_r && line.wp_n) begin
				busy_nxt = 1'b1;
				timer_nxt = NV_CNT_W'(NV_WRITE_CYCLES - 1);
			end
		end
		if (busy_r) begin
			if (timer_r == '0) begin
				busy_nxt = 1'b0;
				preset_nxt[req_r.sel] = req_r.data;
			end else begin
				timer_nxt = timer_r - NV_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wiper_r <= WIPER_MIN;
			for (int i = 0; i < PRESETS; i++) begin
				preset_r[i] <= PRESET_RESET;
			end
			pend_r <= 1'b0;
			req_r <= '0;
			busy_r <= 1'b0;
			timer_r <= '0;
			recall_r <= 1'b1;
		end else begin
			wiper_r <= wiper_nxt;
			preset_r <= preset_nxt;
			pend_r <= pend_nxt;
			req_r <= req_nxt;
			busy_r <= busy_nxt;
			timer_r <= timer_nxt;
			recall_r <= recall_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~drive_r;
	assign wiper_o = wiper_r;
	assign nv_busy_o = busy_r;

endmodule
`default_nettype wire

// File: verif/dtp_slave_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dtp_slave_asserts
	import dtp_pkg::*;
#(
	parameter int unsigned NV_WRITE_CYCLES = NV_WRITE_CYC
)
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic [2:0] addr_strap_inputs_i,
	input wire logic wp_n_i,
	input wire logic [WIPER_W-1:0] wiper_o,
	input wire logic [TAPS-1:0] tap_sel_o,
	input wire logic nv_busy_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ------
	// Busy span
	// ------
	int unsigned busy_cnt_r;
	int unsigned busy_cnt_nxt;
	always_comb begin
		busy_cnt_nxt = nv_busy_o ? busy_cnt_r + 1 : 0;
	end
	always_ff @(posedge clk_sys_i) begin
		busy_cnt_r <= rst_i ? 0 : busy_cnt_nxt;
	end
	chk_sda_value_low: assert property (sda_o == 1'b0)
		else $error("sda value not low");
	chk_tap_one_hot: assert property ($onehot(tap_sel_o))
		else $error("tap select not one-hot");
	chk_tap_follows_wiper: assert property (tap_sel_o == (TAPS'(1) << $past(wiper_o)))
		else $error("tap select off wiper");
	chk_drive_scl_low: assert property ($fell(sda_oe_n_o) |-> !scl_i)
		else $error("sda driven with scl high");
	chk_release_scl_low: assert property ($rose(sda_oe_n_o) |-> !scl_i)
		else $error("sda released with scl high");
	chk_busy_no_ack: assert property (nv_busy_o |-> sda_oe_n_o)
		else $error("sda driven while busy");
	chk_busy_wp_high: assert property ($rose(nv_busy_o) |-> wp_n_i)
		else $error("write began under protect");
	chk_busy_after_stop: assert property ($rose(nv_busy_o) |-> scl_i && sda_i)
		else $error("write began off a stop");
	chk_busy_span_len: assert property ($fell(nv_busy_o) |->
		busy_cnt_r >= NV_WRITE_CYCLES && busy_cnt_r <= NV_WRITE_CYCLES + 2)
		else $error("busy span wrong");
	cov_ack: cover property ($fell(sda_oe_n_o));
	cov_nv_done: cover property ($fell(nv_busy_o));
	cov_top: cover property (wiper_o == WIPER_MAX);
endmodule
bind dtp_slave dtp_slave_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o), .addr_strap_inputs_i(addr_strap_inputs_i), .wp_n_i(wp_n_i),
	.wiper_o(wiper_o), .tap_sel_o(tap_sel_o), .nv_busy_o(nv_busy_o)
);
`default_nettype wire

// File: verif/dtp_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module dtp_master_model (
	input wire logic clk_i,
	input wire logic sda_bus_i,
	output logic scl_o,
	output logic sda_o
);
	// Released lines read high through the pull-up
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Quarter of an 80 ns link period
	task automatic q;
		repeat (5) @(negedge clk_i);
	endtask
	task automatic start;
		sda_o = 1'b1;
		q;
		scl_o = 1'b1;
		q;
		sda_o = 1'b0;
		q;
		scl_o = 1'b0;
	endtask
	task automatic stop;
		q;
		sda_o = 1'b0;
		q;
		scl_o = 1'b1;
		q;
		sda_o = 1'b1;
		q;
	endtask
	// Data moves a quarter period after scl falls, never beside it
	task automatic bit_x(input logic b, output logic r);
		q;
		sda_o = b;
		q;
		scl_o = 1'b1;
		q;
		r = sda_bus_i;
		q;
		scl_o = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] rd, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], rd[i]);
		end
		bit_x(1'b1, r);
		ack = ~r;
	endtask
endmodule
`default_nettype wire

// File: verif/tb_dtp_slave.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dtp_slave
	import dtp_pkg::*;
;
	localparam int NV = 600;
	logic clk;
	logic rst;
	logic scl;
	logic m_sda;
	logic sda_bus;
	logic sda_o;
	logic sda_oe_n;
	logic [2:0] strap;
	logic wp_n;
	logic [WIPER_W-1:0] wiper;
	logic [TAPS-1:0] tap_sel;
	logic busy;
	logic [7:0] adr;
	logic [7:0] rd;
	logic ack;
	int errors;
	int num_checks;
	int cyc;
	assign sda_bus = m_sda & (sda_oe_n | sda_o);
	dtp_slave #(.NV_WRITE_CYCLES(NV)) dut (
		.clk_sys_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
		.addr_strap_inputs_i(strap), .wp_n_i(wp_n), .wiper_o(wiper), .tap_sel_o(tap_sel), .nv_busy_o(busy)
	);
	dtp_master_model master (.clk_i(clk), .sda_bus_i(sda_bus), .scl_o(scl), .sda_o(m_sda));
	always @(posedge clk) cyc <= cyc + 1;
	// ------
	// Shared tasks
	// ------
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results;
		if (errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic head(input logic [7:0] c);
		master.start;
		master.xfer(adr, rd, ack);
		chk("addr ack", 1, ack);
		master.xfer(c, rd, ack);
		chk("cmd ack", 1, ack);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		head(c);
		master.xfer(d, rd, ack);
		chk("data ack", 1, ack);
		master.stop;
	endtask
	task automatic rd_chk(input logic [7:0] c, input logic [5:0] e);
		head(c);
		master.xfer(8'hFF, rd, ack);
		master.stop;
		chk("read", {2'h0, e}, rd);
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_wiper;
		chk("wiper rst", PRESET_RESET, wiper);
		wr(8'hA0, 8'h15);
		chk("wiper", 6'h15, wiper);
		chk("tap", 64'h1 << 6'h15, tap_sel);
		rd_chk(8'h90, 6'h15);
	endtask
	task automatic t_addr;
		for (int i = 0; i < 8; i++) begin
			master.start;
			master.xfer(adr ^ (8'h1 << i), rd, ack);
			master.stop;
			chk("foreign ack", 0, ack);
		end
		strap = 3'h2;
		adr = 8'hA4;
		wr(8'hA0, 8'h07);
		head(8'hA0);
		master.stop;
		chk("abort", 6'h07, wiper);
		master.start;
		master.xfer(adr, rd, ack);
		master.xfer(8'h50, rd, ack);
		master.stop;
		chk("bad op ack", 0, ack);
		strap = 3'h5;
		adr = 8'hA9;
	endtask
	task automatic t_preset;
		int t0;
		wr(8'hC4, 8'h2A);
		t0 = cyc;
		repeat (4) @(negedge clk);
		chk("busy on", 1, busy);
		master.start;
		master.xfer(adr, rd, ack);
		master.stop;
		chk("poll ack", 0, ack);
		while (busy !== 1'b0 && cyc - t0 < 2 * NV) @(negedge clk);
		chk("busy span", 1, cyc - t0 >= NV - 3 && cyc - t0 <= NV + 3);
		rd_chk(8'hB4, 6'h2A);
		head(8'hD4);
		master.stop;
		chk("xfer wiper", 6'h2A, wiper);
	endtask
	task automatic t_protect;
		wp_n = 1'b0;
		wr(8'hC8, 8'h11);
		repeat (8) @(negedge clk);
		chk("busy wp", 0, busy);
		rd_chk(8'hB8, PRESET_RESET);
		wp_n = 1'b1;
		head(8'hEC);
		master.stop;
		repeat (8) @(negedge clk);
		while (busy !== 1'b0 && cyc < 90000) @(negedge clk);
		rd_chk(8'hBC, 6'h2A);
	endtask
	// The stop's scl rise with sda low counts one more step down
	task automatic t_step;
		wr(8'hA0, 8'h3D);
		head(8'h20);
		master.bit_x(1'b1, ack);
		master.bit_x(1'b1, ack);
		master.bit_x(1'b1, ack);
		master.stop;
		chk("wiper up", 6'h3E, wiper);
		wr(8'hA0, 8'h01);
		head(8'h20);
		master.bit_x(1'b0, ack);
		master.bit_x(1'b0, ack);
		master.stop;
		chk("wiper down", WIPER_MIN, wiper);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		strap = 3'h5;
		wp_n = 1'b1;
		adr = 8'hA9;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		t_wiper;
		t_addr;
		t_preset;
		t_protect;
		t_step;
		results;
	end
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		results;
	end
endmodule
`default_nettype wire
